// ### rtl/frr_cfg.svh
// Purpose: named constants for the fault response and retry controller
// Assumes: included by bare name from the controller design file only
// Notes:   status bit positions follow the published power-bus status layout
`ifndef FRR_CFG_SVH
`define FRR_CFG_SVH
// ****************************************
// response byte fields
// ****************************************
`define FRR_ACT_HI        7
`define FRR_ACT_LO        6
`define FRR_RETRY_HI      5
`define FRR_RETRY_LO      3
`define FRR_DEGL_HI       2
`define FRR_DEGL_LO       0
`define FRR_DEGL_FIXED    3'h0
`define FRR_ACT_NONE      2'h0
`define FRR_RETRY_NONE    3'h0
`define FRR_RETRY_INF     3'h7
`define FRR_RESP_RST      8'h00
`define FRR_LIMIT_RST     3'h0
`define FRR_DELAY_RST     24'h000000
// ****************************************
// register select codes
// ****************************************
`define FRR_SEL_OT        3'h0
`define FRR_SEL_UT        3'h1
`define FRR_SEL_VIN_OV    3'h2
`define FRR_SEL_VIN_UV    3'h3
`define FRR_SEL_TON_MAX   3'h4
`define FRR_SEL_LIMIT     3'h5
`define FRR_SEL_DELAY     3'h6
// ****************************************
// status bit positions
// ****************************************
`define FRR_SB_NONE_ABOVE 0
`define FRR_SB_TEMP       2
`define FRR_SB_VIN_UV     3
`define FRR_SW_VOUT       7
`define FRR_SW_INPUT      5
`define FRR_SV_OV_FAULT   7
`define FRR_SV_UV_FAULT   4
`define FRR_ST_OT_FAULT   7
`define FRR_ST_UT_FAULT   4
`define FRR_SO_TON_MAX    2
// ****************************************
// retry timing, in microseconds, seconds and hertz, with derived step and tick counts
// ****************************************
`define FRR_STEP_US       200
`define FRR_CLAMP_US      13100000
`define FRR_QUIET_S       16
`define FRR_CLAMP_STEPS   (`FRR_CLAMP_US / `FRR_STEP_US)
`define FRR_QUIET_STEPS   ((`FRR_QUIET_S * 1000000) / `FRR_STEP_US)
`define FRR_SHARE_HZ      100000
`define FRR_TICKS_PER_STEP ((`FRR_SHARE_HZ * `FRR_STEP_US) / 1000000)
`endif

// ### rtl/frr_pkg.sv
// Purpose: shared types of the fault response and retry controller
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in frr_cfg.svh
package frr_pkg;
    // gray along idle, run, seq off, off, wait, hold
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RUN     = 3'h1,
        ST_SEQ_OFF = 3'h3,
        ST_OFF     = 3'h2,
        ST_WAIT    = 3'h6,
        ST_HOLD    = 3'h7
    } frr_state_e;

    typedef struct packed {
        logic ot;
        logic ut;
        logic vin_ov;
        logic vin_uv;
        logic ton_max;
    } frr_faults_s;

    typedef struct packed {
        logic [7:0] status_byte;
        logic [7:0] word_hi;
        logic [7:0] vin;
        logic [7:0] temp;
        logic [7:0] vout;
    } frr_status_s;
endpackage

// ### rtl/frr_sync3.sv
// Purpose: three-stage synchroniser with rising-edge tick
// Assumes: input is asynchronous to I_CLK
// Notes:   a change counts once stages two and three agree
`timescale 1ns/100ps
module frr_sync3 (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;

    // ****************************************
    // sampling chain
    // ****************************************
    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // filtered level and one-cycle rise
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lvl_r  <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            o_rise <= 1'b0;
            if (s2_r == s3_r) begin
                lvl_r  <= s3_r;
                o_rise <= s3_r & ~lvl_r;
            end
        end
    end
endmodule

// ### rtl/frr_step_timer.sv
// Purpose: counts steps of shared-clock ticks up to a limit
// Assumes: i_tick is a one-cycle pulse per shared-clock rising edge
// Notes:   limit zero reports done at once
`timescale 1ns/100ps
module frr_step_timer #(
    parameter int TICKS  = 20,
    parameter int STEP_W = 17
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clear,
    input  wire logic              i_tick,
    input  wire logic [STEP_W-1:0] i_limit,
    output logic                   o_done
);
    localparam int SUB_W = (TICKS > 1) ? $clog2(TICKS) : 1;
    logic [SUB_W-1:0]  sub_r;
    logic [STEP_W-1:0] step_r;

    // counter stops at the limit so done holds
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            sub_r  <= '0;
            step_r <= '0;
        end else if (i_tick && step_r < i_limit) begin
            if (sub_r == SUB_W'(TICKS - 1)) begin
                sub_r  <= '0;
                step_r <= step_r + STEP_W'(1);
            end else begin
                sub_r <= sub_r + SUB_W'(1);
            end
        end
    end

    assign o_done = (step_r >= i_limit);
endmodule

// ### rtl/frr_ctrl.sv
// Purpose: per-channel fault response, status, alert and timed retry
// Assumes: fault levels come from comparators on I_CLK; shared clock is a pin
// Notes:   off command wins over every fault state
// Notes on behaviour
// RULE1: a temperature or input-voltage fault sets its summary and detail status bits and pulls alert low.
// RULE2: action 00b leaves the channel running when the fault occurs.
// RULE3: action 01b to 11b turns the channel off at once or by sequencing off, per track enable, then retry follows.
// RULE4: retry field 000b makes no restart and the output stays off until the fault is cleared.
// RULE5: a nonzero retry field restarts up to the global limit, stopping on an off command or another fault.
// RULE6: retry settings change only at the next off-then-on sequence.
// RULE7: the deglitch field is fixed at 000b and faults act without filtering.
// RULE8: a turn-on timeout sets the high-byte, output-voltage and timeout bits and pulls alert low.
// RULE9: the host uses the timeout response at startup and the output under-voltage response afterwards; the code has no output under-voltage response.
// RULE10: the programmed retry interval passes between shutdown and each restart.
// RULE11: the retry interval is timed only from shared-clock edges.
// RULE12: the retry interval is clamped at 13.1 s and rounded to the nearest 200 us.
// RULE13: reading the retry interval returns the value last written.
// RULE14: the global limit means none at 0, that many at 1 to 6, unlimited at 7.
// RULE15: the retry counter clears after 16 s without a fault shutdown and on off-then-on.
// RULE16: the interval starts on reaching off, and restart needs retries left and no off command.
`timescale 1ns/100ps
`include "frr_cfg.svh"
module frr_ctrl #(
    parameter int SHARE_TICKS = `FRR_TICKS_PER_STEP,
    parameter int QUIET_STEPS = `FRR_QUIET_STEPS
) (
    input  wire logic                I_CLK,
    input  wire logic                I_RST_N,
    input  wire frr_pkg::frr_faults_s I_FAULTS,
    input  wire logic                I_CMD_ON,
    input  wire logic                I_TRACK_EN,
    input  wire logic                I_OFF_DONE,
    input  wire logic                I_CLEAR_FAULTS,
    input  wire logic                I_SHARE_CLK,
    input  wire logic                I_WR_EN,
    input  wire logic [2:0]          I_WR_SEL,
    input  wire logic [23:0]         I_WR_DATA,
    input  wire logic [2:0]          I_RD_SEL,
    output logic [23:0]              O_RD_DATA,
    output frr_pkg::frr_status_s     O_STATUS,
    output logic                     O_CHAN_EN,
    output logic                     O_SEQ_OFF,
    output logic                     O_HOST_ALERT_N_O,
    output logic                     O_HOST_ALERT_N_OE
);
    import frr_pkg::*;

    localparam int STEP_W = 17;

    frr_state_e        state_r;
    frr_state_e        state_nxt;
    frr_faults_s       flt_prev_r;
    frr_faults_s       flt_edge;
    logic [7:0]        resp_r [5];
    logic [2:0]        limit_r;
    logic [23:0]       delay_r;
    logic [2:0]        retry_act_r [5];
    logic [2:0]        limit_act_r;
    logic [2:0]        retry_cnt_r;
    logic [2:0]        retry_sel_r;
    logic [2:0]        retry_sel_nxt;
    logic              cmd_prev_r;
    logic              cmd_rise;
    logic              shut_req;
    logic              retries_left;
    logic              share_tick;
    logic              wait_done;
    logic              quiet_done;
    logic              faulted_off;
    logic [24:0]       delay_rnd;
    logic [24:0]       delay_steps_full;
    logic [STEP_W-1:0] delay_steps;
    frr_status_s       stat_set;

    // ****************************************
    // shared clock and timers
    // ****************************************
    frr_sync3 u_share_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_async (I_SHARE_CLK),
        .o_rise  (share_tick)
    );

    // round to nearest step, then clamp; the stored value stays untouched
    assign delay_rnd        = {1'b0, delay_r} + 25'(`FRR_STEP_US / 2);  // RULE12
    assign delay_steps_full = delay_rnd / 25'(`FRR_STEP_US);            // RULE12
    assign delay_steps      = (delay_steps_full > 25'(`FRR_CLAMP_STEPS)) ?
                              STEP_W'(`FRR_CLAMP_STEPS) : STEP_W'(delay_steps_full);  // RULE12

    // interval restarts whenever the channel is not waiting
    frr_step_timer #(.TICKS(SHARE_TICKS), .STEP_W(STEP_W)) u_retry_tmr (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_clear (state_r != ST_WAIT),  // RULE16
        .i_tick  (share_tick),          // RULE11
        .i_limit (delay_steps),
        .o_done  (wait_done)
    );

    assign faulted_off = (state_r == ST_SEQ_OFF) || (state_r == ST_OFF) ||
                         (state_r == ST_WAIT) || (state_r == ST_HOLD);

    // quiet timer runs on shared clock too; 16 s never fits a local counter cheaply
    frr_step_timer #(.TICKS(SHARE_TICKS), .STEP_W(STEP_W)) u_quiet_tmr (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_clear (faulted_off),
        .i_tick  (share_tick),
        .i_limit (STEP_W'(QUIET_STEPS)),
        .o_done  (quiet_done)
    );

    // ****************************************
    // register file
    // ****************************************
    // deglitch bits are never stored
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < 5; i++) begin
                resp_r[i] <= `FRR_RESP_RST;
            end
            limit_r <= `FRR_LIMIT_RST;
            delay_r <= `FRR_DELAY_RST;
        end else if (I_WR_EN) begin
            if (I_WR_SEL <= `FRR_SEL_TON_MAX) begin
                resp_r[I_WR_SEL] <= {I_WR_DATA[`FRR_ACT_HI:`FRR_RETRY_LO], `FRR_DEGL_FIXED};  // RULE7
            end else if (I_WR_SEL == `FRR_SEL_LIMIT) begin
                limit_r <= I_WR_DATA[2:0];
            end else if (I_WR_SEL == `FRR_SEL_DELAY) begin
                delay_r <= I_WR_DATA;  // RULE13
            end
        end
    end

    // read mux; unmapped select reads zero
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_RD_DATA <= '0;
        end else if (I_RD_SEL <= `FRR_SEL_TON_MAX) begin
            O_RD_DATA <= {16'h0000, resp_r[I_RD_SEL]};
        end else if (I_RD_SEL == `FRR_SEL_LIMIT) begin
            O_RD_DATA <= {21'h000000, limit_r};
        end else if (I_RD_SEL == `FRR_SEL_DELAY) begin
            O_RD_DATA <= delay_r;  // RULE13
        end else begin
            O_RD_DATA <= '0;
        end
    end

    // ****************************************
    // fault detection
    // ****************************************
    // no filter stage: a fault acts in the cycle it rises
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            flt_prev_r <= '0;
            cmd_prev_r <= 1'b0;
        end else begin
            flt_prev_r <= I_FAULTS;
            cmd_prev_r <= I_CMD_ON;
        end
    end

    assign flt_edge = I_FAULTS & ~flt_prev_r;  // RULE7
    assign cmd_rise = I_CMD_ON & ~cmd_prev_r;

    // last match wins, so scanning upward lets ot (bit 4) take priority
    always_comb begin
        shut_req      = 1'b0;
        retry_sel_nxt = `FRR_RETRY_NONE;
        for (int i = 0; i <= 4; i++) begin
            if (flt_edge[i] && resp_r[4-i][`FRR_ACT_HI:`FRR_ACT_LO] != `FRR_ACT_NONE) begin  // RULE2
                shut_req      = 1'b1;  // RULE3
                retry_sel_nxt = retry_act_r[4-i];
            end
        end
    end

    // ****************************************
    // status and alert
    // ****************************************
    always_comb begin
        stat_set = '0;
        stat_set.temp[`FRR_ST_OT_FAULT]       = flt_edge.ot;  // RULE1
        stat_set.temp[`FRR_ST_UT_FAULT]       = flt_edge.ut;  // RULE1
        stat_set.vin[`FRR_SV_OV_FAULT]        = flt_edge.vin_ov;  // RULE1
        stat_set.vin[`FRR_SV_UV_FAULT]        = flt_edge.vin_uv;  // RULE1
        stat_set.status_byte[`FRR_SB_TEMP]    = flt_edge.ot | flt_edge.ut;  // RULE1
        stat_set.status_byte[`FRR_SB_VIN_UV]  = flt_edge.vin_uv;  // RULE1
        stat_set.word_hi[`FRR_SW_INPUT]       = flt_edge.vin_ov | flt_edge.vin_uv;  // RULE1
        stat_set.vout[`FRR_SO_TON_MAX]        = flt_edge.ton_max;  // RULE8
        stat_set.word_hi[`FRR_SW_VOUT]        = flt_edge.ton_max;  // RULE8
        stat_set.status_byte[`FRR_SB_NONE_ABOVE] = flt_edge.ton_max;  // RULE8
    end

    // a set in the clearing cycle survives
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_STATUS <= '0;
        end else if (I_CLEAR_FAULTS) begin
            O_STATUS <= stat_set;
        end else begin
            O_STATUS <= O_STATUS | stat_set;
        end
    end

    // open drain: only ever drives low
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_HOST_ALERT_N_O  <= 1'b0;
            O_HOST_ALERT_N_OE <= 1'b0;
        end else begin
            O_HOST_ALERT_N_O  <= 1'b0;
            O_HOST_ALERT_N_OE <= |O_STATUS;  // RULE1 RULE8
        end
    end

    // ****************************************
    // retry settings and counter
    // ****************************************
    // snapshot at turn-on so a mid-run write waits for the next cycle of power
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < 5; i++) begin
                retry_act_r[i] <= `FRR_RETRY_NONE;
            end
            limit_act_r <= `FRR_LIMIT_RST;
        end else if (cmd_rise) begin
            for (int i = 0; i < 5; i++) begin
                retry_act_r[i] <= resp_r[i][`FRR_RETRY_HI:`FRR_RETRY_LO];  // RULE6
            end
            limit_act_r <= limit_r;  // RULE6
        end
    end

    assign retries_left = (limit_act_r == `FRR_RETRY_INF) || (retry_cnt_r < limit_act_r);  // RULE14

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            retry_cnt_r <= '0;
        end else if (cmd_rise || (quiet_done && !faulted_off)) begin
            retry_cnt_r <= '0;  // RULE15
        end else if (state_r == ST_WAIT && wait_done && I_CMD_ON && flt_edge == '0 &&
                     limit_act_r != `FRR_RETRY_INF) begin
            retry_cnt_r <= retry_cnt_r + 3'h1;  // RULE14
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            retry_sel_r <= `FRR_RETRY_NONE;
        end else if (state_r == ST_RUN && shut_req) begin
            retry_sel_r <= retry_sel_nxt;
        end
    end

    // ****************************************
    // channel state machine
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (I_CMD_ON) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (shut_req) begin
                    state_nxt = I_TRACK_EN ? ST_SEQ_OFF : ST_OFF;  // RULE3
                end
            end
            ST_SEQ_OFF: begin
                if (I_OFF_DONE) begin
                    state_nxt = ST_OFF;  // RULE3
                end
            end
            ST_OFF: begin
                if (retry_sel_r == `FRR_RETRY_NONE) begin
                    state_nxt = ST_HOLD;  // RULE4
                end else if (!retries_left) begin
                    state_nxt = ST_HOLD;  // RULE5
                end else begin
                    state_nxt = ST_WAIT;  // RULE16
                end
            end
            ST_WAIT: begin
                if (|flt_edge) begin
                    state_nxt = ST_HOLD;  // RULE5
                end else if (wait_done) begin
                    state_nxt = ST_RUN;  // RULE10
                end
            end
            ST_HOLD: begin
                if (I_CLEAR_FAULTS && I_FAULTS == '0) begin
                    state_nxt = ST_RUN;  // RULE4
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!I_CMD_ON) begin
            state_nxt = ST_IDLE;  // RULE5 RULE16
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs follow the next state so they leave a flop with the state
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_CHAN_EN <= 1'b0;
            O_SEQ_OFF <= 1'b0;
        end else begin
            O_CHAN_EN <= (state_nxt == ST_RUN) || (state_nxt == ST_SEQ_OFF);  // RULE2 RULE3
            O_SEQ_OFF <= (state_nxt == ST_SEQ_OFF);  // RULE3
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_ot_flag;
        O_STATUS.temp[`FRR_ST_OT_FAULT] && O_STATUS.status_byte[`FRR_SB_TEMP];
    endsequence

    sequence s_alert_low;
        O_HOST_ALERT_N_OE && !O_HOST_ALERT_N_O;
    endsequence

    property p_ot_alert;
        @(posedge I_CLK) disable iff (!I_RST_N)
        $rose(I_FAULTS.ot) |-> ##1 s_ot_flag ##1 s_alert_low;
    endproperty
    a_ot_alert: assert property (p_ot_alert) else $error("ot fault did not flag and alert");  // RULE1

    property p_ton_flags;
        @(posedge I_CLK) disable iff (!I_RST_N)
        $rose(I_FAULTS.ton_max) |=> O_STATUS.vout[`FRR_SO_TON_MAX] && O_STATUS.word_hi[`FRR_SW_VOUT]
                                    && O_STATUS.status_byte[`FRR_SB_NONE_ABOVE];
    endproperty
    a_ton_flags: assert property (p_ton_flags) else $error("timeout fault bits missing");  // RULE8

    property p_no_action_runs;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (state_r == ST_RUN && I_CMD_ON && |flt_edge && !shut_req) |=> O_CHAN_EN && state_r == ST_RUN;
    endproperty
    a_no_action_runs: assert property (p_no_action_runs) else $error("channel stopped on 00b action");  // RULE2

    property p_shut_now;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (state_r == ST_RUN && shut_req && !I_TRACK_EN) |=> !O_CHAN_EN ##1 state_r != ST_RUN;
    endproperty
    a_shut_now: assert property (p_shut_now) else $error("immediate shutdown missing");  // RULE3

    property p_no_retry_holds;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (state_r == ST_OFF && I_CMD_ON && retry_sel_r == `FRR_RETRY_NONE) |=> state_r == ST_HOLD [*2];
    endproperty
    a_no_retry_holds: assert property (p_no_retry_holds) else $error("restart with retry 000b");  // RULE4

    property p_limit_stops;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (state_r == ST_OFF && I_CMD_ON && !retries_left) |=> state_r == ST_HOLD;
    endproperty
    a_limit_stops: assert property (p_limit_stops) else $error("retry beyond limit");  // RULE5 RULE14

    property p_setting_frozen;
        @(posedge I_CLK) disable iff (!I_RST_N)
        !cmd_rise |=> $stable(limit_act_r);
    endproperty
    a_setting_frozen: assert property (p_setting_frozen) else $error("retry limit changed mid-run");  // RULE6

    property p_degl_zero;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_RD_SEL <= `FRR_SEL_TON_MAX) |=> O_RD_DATA[`FRR_DEGL_HI:`FRR_DEGL_LO] == `FRR_DEGL_FIXED;
    endproperty
    a_degl_zero: assert property (p_degl_zero) else $error("deglitch field not zero");  // RULE7

    property p_wait_holds;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (state_r == ST_WAIT && !wait_done && I_CMD_ON && flt_edge == '0) |=> state_r == ST_WAIT && !O_CHAN_EN;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("restart before interval");  // RULE10 RULE16

    property p_clamp;
        @(posedge I_CLK) disable iff (!I_RST_N)
        delay_steps <= STEP_W'(`FRR_CLAMP_STEPS);
    endproperty
    a_clamp: assert property (p_clamp) else $error("retry interval above clamp");  // RULE12

    property p_delay_readback;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_WR_EN && I_WR_SEL == `FRR_SEL_DELAY) ##1 (I_RD_SEL == `FRR_SEL_DELAY && !I_WR_EN)
        |=> O_RD_DATA == $past(I_WR_DATA, 2);
    endproperty
    a_delay_readback: assert property (p_delay_readback) else $error("retry delay readback wrong");  // RULE13

    property p_cnt_clear;
        @(posedge I_CLK) disable iff (!I_RST_N)
        cmd_rise |=> retry_cnt_r == 3'h0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("retry count not cleared");  // RULE15
endmodule

// ### verification/frr_far_model.sv
// Purpose: off sequencer and shared clock source facing the channel
// Assumes: sequence off request is a level
// Notes:   shared clock stands still unless enabled
`timescale 1ns/100ps
module frr_far_model (
    input  wire logic i_clk,
    input  wire logic i_seq_off,
    input  wire logic i_share_run,
    output logic      o_off_done,
    output logic      o_share_clk
);
    logic [3:0] cnt_r = 4'h0;
    logic [3:0] off_r = 4'h0;
    initial begin
        o_off_done = 1'b0;
        o_share_clk = 1'b0;
    end
    // slow answer: done eight cycles into a request, so the off wait is real
    always @(posedge i_clk) begin
        #1;
        cnt_r <= cnt_r + 4'h1;
        off_r <= i_seq_off ? off_r + {3'h0, ~off_r[3]} : 4'h0;
        if (cnt_r == 4'h0 && i_share_run) o_share_clk <= ~o_share_clk;
        o_off_done <= i_seq_off && off_r[3];
    end
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench for the fault response controller
// Assumes: short step and quiet counts set by parameter
// Notes:   expectations queued by the driver, compared by a watcher
`timescale 1ns/100ps
module tb_top;
    import frr_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, cmd_on = 1'b0, track = 1'b0, clr = 1'b0, wr_en = 1'b0, run = 1'b0;
    logic [2:0]  wr_sel = 3'h0, rd_sel = 3'h0;
    logic [23:0] wr_data = 24'h0, rd_data, d;
    frr_faults_s faults = '0;
    frr_status_s st;
    logic        en, seq, a_o, a_oe, done, sclk;
    logic [39:0] seen_q[$], exp_q[$];
    int          n_fail = 0, checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    frr_ctrl #(.SHARE_TICKS(1), .QUIET_STEPS(4)) uut (.I_CLK(clk), .I_RST_N(rst_n), .I_FAULTS(faults),
        .I_CMD_ON(cmd_on), .I_TRACK_EN(track), .I_OFF_DONE(done), .I_CLEAR_FAULTS(clr), .I_SHARE_CLK(sclk),
        .I_WR_EN(wr_en), .I_WR_SEL(wr_sel), .I_WR_DATA(wr_data), .I_RD_SEL(rd_sel), .O_RD_DATA(rd_data),
        .O_STATUS(st), .O_CHAN_EN(en), .O_SEQ_OFF(seq), .O_HOST_ALERT_N_O(a_o), .O_HOST_ALERT_N_OE(a_oe));
    frr_far_model far (.i_clk(clk), .i_seq_off(seq), .i_share_run(run), .o_off_done(done), .o_share_clk(sclk));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic note(input logic [39:0] s, input logic [39:0] e);
        seen_q.push_back(s);
        exp_q.push_back(e);
    endtask
    task automatic check(input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // watcher drains notes in order each cycle
    always @(posedge clk) while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
    task automatic wr(input logic [2:0] s, input logic [23:0] v);
        wr_en = 1'b1;
        wr_sel = s;
        wr_data = v;
        tick(1);
    endtask
    // write strobe stays up between writes; a read drops it
    task automatic rd(input logic [2:0] s, input logic [23:0] e);
        wr_en = 1'b0;
        rd_sel = s;
        tick(1);
        note(rd_data, e);
    endtask
    // bounded wait so a stuck channel cannot hang the run
    task automatic wait_en(input logic v, input int n);
        for (int i = 0; i < n && en !== v; i++) tick(1);
        note(en, v);
    endtask
    task automatic report_and_stop();
        tick(2);
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(43863));
        tick(20);
        rst_n = 1'b1;
        d = 24'($urandom());
        wr(3'h6, d);
        rd(3'h6, d);
        wr(3'h1, 24'h47);
        rd(3'h1, 24'h40);
        wr(3'h7, 24'h5A);
        rd(3'h7, 24'h0);
        $display("test registers done");
        wr(3'h0, 24'h07);
        wr(3'h2, 24'h48);
        wr(3'h4, 24'h40);
        wr(3'h5, 24'h1);
        wr(3'h6, 24'd400);
        wr_en = 1'b0;
        cmd_on = 1'b1;
        tick(2);
        faults.ot = 1'b1;
        tick(3);
        note(en, 1'b1);
        note({st.temp[7], st.status_byte[2], a_oe, a_o}, 4'hE);
        faults.ot = 1'b0;
        $display("test continue done");
        faults.vin_ov = 1'b1;
        tick(2);
        note({en, st.vin[7], st.word_hi[5]}, 3'h3);
        tick(100);
        note(en, 1'b0);
        faults.vin_ov = 1'b0;
        run = 1'b1;
        wait_en(1'b1, 300);
        faults.vin_ov = 1'b1;
        tick(300);
        note(en, 1'b0);
        faults.vin_ov = 1'b0;
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(2);
        note({en, st.vin}, 9'h100);
        $display("test retry done");
        track = 1'b1;
        faults.ton_max = 1'b1;
        tick(2);
        note({seq, st.vout[2], st.word_hi[7], st.status_byte[0]}, 4'hF);
        tick(40);
        note({en, seq}, 2'h0);
        faults.ut = 1'b1;
        faults.vin_uv = 1'b1;
        tick(2);
        note({st.temp[4], st.vin[4], st.status_byte[3:2], st.word_hi[5]}, 5'h1F);
        $display("test timeout done");
        report_and_stop();
    end
endmodule
